//--- verilog/lu_cfg.svh
`ifndef LU_CFG_SVH
`define LU_CFG_SVH

// ----------------------------------------
// Register offsets (6-bit serial address)
// ----------------------------------------
`define LU_LCS1_ADDR      6'h10
`define LU_LCS2_ADDR      6'h11

// ----------------------------------------
// Field positions, first register
// ----------------------------------------
`define LU_LCS1_MARKS     7
`define LU_LCS1_LLB       6
`define LU_LCS1_RLB       5
`define LU_LCS1_BO_HI     4
`define LU_LCS1_BO_LO     3
`define LU_LCS1_ZSUB      2
`define LU_LCS1_NETLB     1
`define LU_LCS1_LOS       0

// ----------------------------------------
// Field positions, second register
// ----------------------------------------
`define LU_LCS2_AIS       7
`define LU_LCS2_RAMP      6
`define LU_LCS2_LDN       4
`define LU_LCS2_LUP       3
`define LU_LCS2_RPD       2
`define LU_LCS2_HIZ       1

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define LU_REG_RST        8'h00
`define LU_SYNC_RST       10'h100
`define LU_LOS_ZEROS      8'hAF
`define LU_LUP_LAST       3'h4
`define LU_LDN_LAST       3'h2
`define LU_LAST_BIT       4'h7

`endif

//--- verilog/lu_pkg.sv
package lu_pkg;

    // Serial port frame phase
    typedef enum logic [1:0] {
        SP_IDLE = 2'b00,
        SP_CMD  = 2'b01,
        SP_DATA = 2'b10,
        SP_DONE = 2'b11
    } lu_sp_state_t;

endpackage : lu_pkg

//--- verilog/lu_line_ctrl.sv
// Contract
// - Marks bit sends ones on transmit clock
// - Coder mode: zero-substitution bit enables B8ZS
// - Non-coder mode: same bit sends all zeros
// - Network loopback bit shows detected code
// - Loopback status change interrupts unless masked
// - Signal-loss bit sets after 175 zeros
// - Signal-loss bit clear with valid signal (the code clears it on the first received one)
// - Signal-loss change interrupts unless masked
// - All-ones alarm set while pattern present
// - Alarm holds until first read after end
// - Alarm interrupts while present and until the first read after end, unless masked
// - RAM pulse bit selects programmed shapes
// - Loop-down bit repeats pattern 001
// - Loop-up bit repeats pattern 00001
// - Receiver power-down keeps transmitter active
// - High-impedance bit parks line driver
// - Local loopback routes transmit to receive
// - Remote loopback returns received line, beats marks
// - Both loopbacks written: clear all, recalibrate
// - Writing one clears and masks; zero unmasks
`include "lu_cfg.svh"
`timescale 1ns/100ps
module lu_line_ctrl
    import lu_pkg::*;
(
    // Clock and reset
    input  wire logic       I_MCLK,
    input  wire logic       I_RESET_N,
    // Serial control port
    input  wire logic       I_SCLK,
    input  wire logic       I_CS_N,
    input  wire logic       I_SDI,
    output logic            O_SDO,
    output logic            O_SDO_OE,
    // Transmit side
    input  wire logic       I_TX_CLOCK_IN,
    input  wire logic       I_TX_POS_DATA_IN,
    input  wire logic       I_TX_NEGATIVE_DATA_IN,
    output logic            O_TX_LINE_CLK,
    output logic            O_TX_LINE_DATA,
    // Receive side
    input  wire logic       I_RX_LINE_CLK,
    input  wire logic       I_RX_LINE_DATA,
    input  wire logic       I_NETLB_CODE_DET,
    input  wire logic       I_ALL_ONES_COND,
    output logic            O_RX_CLK,
    output logic            O_RX_DATA,
    // Analog controls
    output logic [1:0]      O_BUILDOUT,
    output logic            O_B8ZS_EN,
    output logic            O_RAM_PULSE_SEL,
    output logic            O_RX_POWER_DOWN,
    output logic            O_DRIVER_HIGH_Z,
    output logic            O_CAL_RESTART,
    // Interrupt
    output logic            O_INT_N
);

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [9:0]   sync1_r, sync2_r, sync3_r;
    logic [9:0]   sync1_nxt, sync2_nxt, sync3_nxt;

    always_comb begin
        sync1_nxt = {I_SCLK, I_CS_N, I_SDI, I_TX_CLOCK_IN, I_TX_POS_DATA_IN,
                     I_TX_NEGATIVE_DATA_IN, I_RX_LINE_CLK, I_RX_LINE_DATA,
                     I_NETLB_CODE_DET, I_ALL_ONES_COND};
        sync2_nxt = sync1_r;
        sync3_nxt = sync2_r;
    end

    always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            sync1_r <= `LU_SYNC_RST;
            sync2_r <= `LU_SYNC_RST;
            sync3_r <= `LU_SYNC_RST;
        end else begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
            sync3_r <= sync3_nxt;
        end
    end

    logic  sclk_rise, sclk_fall, cs_n_s, sdi_s, tx_clk_s, tx_rise, tx_pos_s, coder_s;
    logic  rx_clk_s, rx_rise, rx_data_s, netlb_s, ais_s;
    assign sclk_rise = sync2_r[9] & ~sync3_r[9];
    assign sclk_fall = ~sync2_r[9] & sync3_r[9];
    assign cs_n_s    = sync2_r[8];
    assign sdi_s     = sync2_r[7];
    assign tx_clk_s  = sync2_r[6];
    assign tx_rise   = sync2_r[6] & ~sync3_r[6];
    assign tx_pos_s  = sync2_r[5];
    assign coder_s   = sync2_r[4];
    assign rx_clk_s  = sync2_r[3];
    assign rx_rise   = sync2_r[3] & ~sync3_r[3];
    assign rx_data_s = sync2_r[2];
    assign netlb_s   = sync2_r[1];
    assign ais_s     = sync2_r[0];

    // ----------------------------------------
    // Register storage
    // ----------------------------------------
    // Mask bits live in the stored status positions of both registers
    logic [7:0]   lcs1_r, lcs2_r, lcs1_nxt, lcs2_nxt;
    logic         los_r, netlb_r, ais_r;
    logic         wr_take, rd_ais, soft_clr;
    logic [7:0]   wdata;
    logic [5:0]   addr_r;
    logic [7:0]   lcs1_rd, lcs2_rd;

    assign lcs1_rd = {lcs1_r[7:2], netlb_r, los_r};
    assign lcs2_rd = {ais_r, lcs2_r[6], 1'b0, lcs2_r[4:1], 1'b0};
    assign soft_clr = wr_take && addr_r == `LU_LCS1_ADDR
                      && wdata[`LU_LCS1_LLB] && wdata[`LU_LCS1_RLB];

    always_comb begin
        lcs1_nxt = lcs1_r;
        lcs2_nxt = lcs2_r;
        if (soft_clr) begin
            lcs1_nxt = `LU_REG_RST;
            lcs2_nxt = `LU_REG_RST;
        end else if (wr_take && addr_r == `LU_LCS1_ADDR) begin
            lcs1_nxt = wdata;
        end else if (wr_take && addr_r == `LU_LCS2_ADDR) begin
            lcs2_nxt = wdata;
        end
    end

    always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            lcs1_r <= `LU_REG_RST;
            lcs2_r <= `LU_REG_RST;
        end else begin
            lcs1_r <= lcs1_nxt;
            lcs2_r <= lcs2_nxt;
        end
    end

    // ----------------------------------------
    // Serial control port
    // ----------------------------------------
    // First bit is read/write, then six address bits, one ignored, LSB first
    lu_sp_state_t sp_r, sp_nxt;
    logic [3:0]   cnt_r, cnt_nxt;
    logic [7:0]   sh_r, sh_nxt, out_r, out_nxt;
    logic         rw_r, rw_nxt, sdo_r, sdo_nxt, oe_r, oe_nxt;
    logic [5:0]   addr_nxt;

    assign wdata = sh_nxt;

    always_comb begin
        sp_nxt   = sp_r;
        cnt_nxt  = cnt_r;
        sh_nxt   = sh_r;
        out_nxt  = out_r;
        rw_nxt   = rw_r;
        addr_nxt = addr_r;
        sdo_nxt  = sdo_r;
        oe_nxt   = oe_r;
        wr_take  = 1'b0;
        rd_ais   = 1'b0;
        if (sclk_rise) begin
            sh_nxt = {sdi_s, sh_r[7:1]};
        end
        if (cs_n_s) begin
            sp_nxt  = SP_IDLE;
            cnt_nxt = 4'h0;
            oe_nxt  = 1'b0;
        end else begin
            unique case (sp_r)
                SP_IDLE: begin
                    sp_nxt  = SP_CMD;
                    cnt_nxt = 4'h0;
                end
                SP_CMD: begin
                    if (sclk_rise) begin
                        cnt_nxt = cnt_r + 4'h1;
                        if (cnt_r == `LU_LAST_BIT) begin
                            rw_nxt   = sh_r[1];
                            addr_nxt = sh_nxt[6:1];
                            cnt_nxt  = 4'h0;
                            sp_nxt   = SP_DATA;
                            out_nxt  = (sh_nxt[6:1] == `LU_LCS1_ADDR) ? lcs1_rd :
                                       (sh_nxt[6:1] == `LU_LCS2_ADDR) ? lcs2_rd : 8'h00;
                            rd_ais   = sh_r[1] && sh_nxt[6:1] == `LU_LCS2_ADDR;
                        end
                    end
                end
                SP_DATA: begin
                    if (sclk_fall && rw_r) begin
                        sdo_nxt = out_r[0];
                        out_nxt = {1'b0, out_r[7:1]};
                        oe_nxt  = 1'b1;
                    end
                    if (sclk_rise) begin
                        cnt_nxt = cnt_r + 4'h1;
                        if (cnt_r == `LU_LAST_BIT) begin
                            wr_take = ~rw_r;
                            sp_nxt  = SP_DONE;
                        end
                    end
                end
                SP_DONE: begin
                    if (sclk_rise) begin
                        oe_nxt = 1'b0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            sp_r   <= SP_IDLE;
            cnt_r  <= 4'h0;
            sh_r   <= 8'h00;
            out_r  <= 8'h00;
            rw_r   <= 1'b0;
            addr_r <= 6'h00;
            sdo_r  <= 1'b0;
            oe_r   <= 1'b0;
        end else begin
            sp_r   <= sp_nxt;
            cnt_r  <= cnt_nxt;
            sh_r   <= sh_nxt;
            out_r  <= out_nxt;
            rw_r   <= rw_nxt;
            addr_r <= addr_nxt;
            sdo_r  <= sdo_nxt;
            oe_r   <= oe_nxt;
        end
    end

    // ----------------------------------------
    // Line status and interrupt
    // ----------------------------------------
    // Exit from signal loss is simplified to the first received one
    logic [7:0]   zcnt_r, zcnt_nxt;
    logic         los_nxt, netlb_nxt, ais_nxt;
    logic         los_pend_r, los_pend_nxt, nl_pend_r, nl_pend_nxt;
    logic         int_n_r, int_n_nxt, cal_r, cal_nxt;
    logic         los_clr, nl_clr, rx_live;

    assign los_clr = wr_take && addr_r == `LU_LCS1_ADDR && wdata[`LU_LCS1_LOS];
    assign nl_clr  = wr_take && addr_r == `LU_LCS1_ADDR && wdata[`LU_LCS1_NETLB];
    assign rx_live = rx_rise && !lcs1_r[`LU_LCS1_LLB] && !lcs2_r[`LU_LCS2_RPD];

    always_comb begin
        zcnt_nxt  = zcnt_r;
        los_nxt   = los_r;
        netlb_nxt = netlb_s;
        ais_nxt   = ais_s | (ais_r & ~rd_ais);
        if (rx_live) begin
            if (rx_data_s) begin
                zcnt_nxt = 8'h00;
                los_nxt  = 1'b0;
            end else if (zcnt_r != `LU_LOS_ZEROS) begin
                zcnt_nxt = zcnt_r + 8'h01;
                if (zcnt_nxt == `LU_LOS_ZEROS) begin
                    los_nxt = 1'b1;
                end
            end
        end
        // Set wins over a clear in the same cycle
        los_pend_nxt = (los_pend_r & ~los_clr)
                       | ((los_nxt ^ los_r) & ~lcs1_r[`LU_LCS1_LOS]);
        nl_pend_nxt  = (nl_pend_r & ~nl_clr)
                       | ((netlb_nxt ^ netlb_r) & ~lcs1_r[`LU_LCS1_NETLB]);
        int_n_nxt    = ~(los_pend_r | nl_pend_r
                         | (ais_r & ~lcs2_r[`LU_LCS2_AIS]));
        cal_nxt      = soft_clr;
        if (soft_clr) begin
            zcnt_nxt     = 8'h00;
            los_nxt      = 1'b0;
            ais_nxt      = 1'b0;
            los_pend_nxt = 1'b0;
            nl_pend_nxt  = 1'b0;
        end
    end

    always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            zcnt_r     <= 8'h00;
            los_r      <= 1'b0;
            netlb_r    <= 1'b0;
            ais_r      <= 1'b0;
            los_pend_r <= 1'b0;
            nl_pend_r  <= 1'b0;
            int_n_r    <= 1'b1;
            cal_r      <= 1'b0;
        end else begin
            zcnt_r     <= zcnt_nxt;
            los_r      <= los_nxt;
            netlb_r    <= netlb_nxt;
            ais_r      <= ais_nxt;
            los_pend_r <= los_pend_nxt;
            nl_pend_r  <= nl_pend_nxt;
            int_n_r    <= int_n_nxt;
            cal_r      <= cal_nxt;
        end
    end

    // ----------------------------------------
    // Transmit and receive data paths
    // ----------------------------------------
    logic [2:0]   ph5_r, ph5_nxt, ph3_r, ph3_nxt;
    logic         txd_r, txd_nxt, txc_r, txc_nxt, rxd_r, rxd_nxt, rxc_r, rxc_nxt;
    logic         b8_r, b8_nxt, tx_take;

    assign tx_take = lcs1_r[`LU_LCS1_RLB] ? rx_rise : tx_rise;

    always_comb begin
        ph5_nxt = ph5_r;
        ph3_nxt = ph3_r;
        txd_nxt = txd_r;
        rxd_nxt = rxd_r;
        txc_nxt = lcs1_r[`LU_LCS1_RLB] ? rx_clk_s : tx_clk_s;
        rxc_nxt = lcs1_r[`LU_LCS1_LLB] ? tx_clk_s : rx_clk_s;
        b8_nxt  = coder_s & lcs1_r[`LU_LCS1_ZSUB];
        if (tx_rise) begin
            ph5_nxt = (ph5_r == `LU_LUP_LAST) ? 3'h0 : ph5_r + 3'h1;
            ph3_nxt = (ph3_r == `LU_LDN_LAST) ? 3'h0 : ph3_r + 3'h1;
        end
        if (tx_take) begin
            if (lcs1_r[`LU_LCS1_RLB]) begin
                txd_nxt = rx_data_s;
            end else if (lcs1_r[`LU_LCS1_MARKS]) begin
                txd_nxt = 1'b1;
            end else if (lcs2_r[`LU_LCS2_LUP]) begin
                txd_nxt = (ph5_r == `LU_LUP_LAST);
            end else if (lcs2_r[`LU_LCS2_LDN]) begin
                txd_nxt = (ph3_r == `LU_LDN_LAST);
            end else if (lcs1_r[`LU_LCS1_ZSUB] && !coder_s) begin
                txd_nxt = 1'b0;
            end else begin
                txd_nxt = tx_pos_s;
            end
        end
        if (lcs1_r[`LU_LCS1_LLB]) begin
            if (tx_rise) begin
                rxd_nxt = tx_pos_s;
            end
        end else if (rx_rise) begin
            rxd_nxt = rx_data_s & ~los_r & ~lcs2_r[`LU_LCS2_RPD];
        end
    end

    always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            ph5_r <= 3'h0;
            ph3_r <= 3'h0;
            txd_r <= 1'b0;
            txc_r <= 1'b0;
            rxd_r <= 1'b0;
            rxc_r <= 1'b0;
            b8_r  <= 1'b0;
        end else begin
            ph5_r <= ph5_nxt;
            ph3_r <= ph3_nxt;
            txd_r <= txd_nxt;
            txc_r <= txc_nxt;
            rxd_r <= rxd_nxt;
            rxc_r <= rxc_nxt;
            b8_r  <= b8_nxt;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign O_SDO           = sdo_r;
    assign O_SDO_OE        = oe_r;
    assign O_TX_LINE_CLK   = txc_r;
    assign O_TX_LINE_DATA  = txd_r;
    assign O_RX_CLK        = rxc_r;
    assign O_RX_DATA       = rxd_r;
    assign O_BUILDOUT      = lcs1_r[`LU_LCS1_BO_HI:`LU_LCS1_BO_LO];
    assign O_B8ZS_EN       = b8_r;
    assign O_RAM_PULSE_SEL = lcs2_r[`LU_LCS2_RAMP];
    assign O_RX_POWER_DOWN = lcs2_r[`LU_LCS2_RPD];
    assign O_DRIVER_HIGH_Z = lcs2_r[`LU_LCS2_HIZ];
    assign O_CAL_RESTART   = cal_r;
    assign O_INT_N         = int_n_r;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    los_set_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        rx_live && !rx_data_s && zcnt_r == `LU_LOS_ZEROS - 8'h01 && !soft_clr |=> los_r)
        else $error("signal loss not set at zero count");
    los_clear_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        rx_live && rx_data_s |=> !los_r && zcnt_r == 8'h00)
        else $error("signal loss not cleared by a one");
    marks_tx_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        tx_rise && lcs1_r[`LU_LCS1_MARKS] && !lcs1_r[`LU_LCS1_RLB] |=> O_TX_LINE_DATA)
        else $error("all ones not sent");
    loop_up_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        tx_rise && lcs2_r[`LU_LCS2_LUP] && lcs1_r[7:5] == 3'h0 |=> O_TX_LINE_DATA == (ph5_r == 3'h0))
        else $error("loop-up pattern wrong");
    loop_dn_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        tx_rise && lcs2_r[4:3] == 2'h2 && lcs1_r[7:5] == 3'h0 |=> O_TX_LINE_DATA == (ph3_r == 3'h0))
        else $error("loop-down pattern wrong");
    los_irq_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        los_nxt != los_r && !lcs1_r[`LU_LCS1_LOS] && !soft_clr |=> los_pend_r ##1 !O_INT_N)
        else $error("signal loss change gave no interrupt");
    nl_irq_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        $changed(netlb_r) && !$past(lcs1_r[`LU_LCS1_NETLB]) && !$past(soft_clr) |-> nl_pend_r)
        else $error("loopback change gave no interrupt");
    ais_hold_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        ais_r && !rd_ais && !soft_clr |=> ais_r)
        else $error("alarm dropped without a read");
    soft_clr_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        soft_clr |=> lcs1_r == 8'h00 && lcs2_r == 8'h00 && O_CAL_RESTART)
        else $error("double loopback write did not clear");
    int_mask_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        los_clr && !(los_nxt ^ los_r) |=> !los_pend_r)
        else $error("writing one did not clear interrupt");

endmodule : lu_line_ctrl

//--- tb/lu_host_model.sv
`timescale 1ns/100ps
module lu_host_model (
    // Clock
    input  wire logic i_clk,
    // Serial port
    output logic      o_sclk,
    output logic      o_cs_n,
    output logic      o_sdi,
    input  wire logic i_sdo,
    input  wire logic i_sdo_oe
);
    // --------
    // Serial host
    // --------
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_sdi  = 1'b0;
    end

    task automatic gap(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : gap

    // Eight clocks per level, well above the port's minimum
    task automatic xfer(input logic rd, input logic [5:0] adr, input logic [7:0] wd, output logic [7:0] q);
        logic [15:0] frame;
        frame  = {((adr == 6'h11) ? (wd & 8'hDE) : wd), 1'b0, adr, rd};
        q      = 8'h00;
        o_cs_n = 1'b0;
        for (int i = 0; i < 16; i++) begin
            o_sdi = frame[i];
            gap(8);
            // Undriven output reads as unknown so it never passes
            if (i >= 8) q[i-8] = i_sdo_oe ? i_sdo : 1'bx;
            o_sclk = 1'b1;
            gap(8);
            o_sclk = 1'b0;
        end
        gap(8);
        o_cs_n = 1'b1;
        o_sdi  = 1'b0;
        gap(8);
    endtask : xfer
endmodule : lu_host_model

//--- tb/t1_line_unit_control_regs_tb.sv
`timescale 1ns/100ps
module t1_line_unit_control_regs_tb;
    logic        mclk, rst_n, tck, tpos, tx_negative_data_in, rck, rdat, nl_det, ones, cal_seen;
    wire         sclk, cs_n, sdi, sdo, sdo_oe, tx_lclk, tx_ldat, rx_ck, rx_d;
    wire  [1:0]  bo;
    wire         b8zs, ramp, rpd, hiz, cal, int_n;
    int          fail_count, checks_done;
    logic [7:0]  rv;
    logic [14:0] bits;

    lu_host_model u_host (.i_clk(mclk), .o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi), .i_sdo(sdo), .i_sdo_oe(sdo_oe));

    lu_line_ctrl u_lu_line_ctrl (
        .I_MCLK(mclk), .I_RESET_N(rst_n), .I_SCLK(sclk), .I_CS_N(cs_n), .I_SDI(sdi),
        .O_SDO(sdo), .O_SDO_OE(sdo_oe), .I_TX_CLOCK_IN(tck), .I_TX_POS_DATA_IN(tpos),
        .I_TX_NEGATIVE_DATA_IN(tx_negative_data_in), .O_TX_LINE_CLK(tx_lclk), .O_TX_LINE_DATA(tx_ldat),
        .I_RX_LINE_CLK(rck), .I_RX_LINE_DATA(rdat), .I_NETLB_CODE_DET(nl_det),
        .I_ALL_ONES_COND(ones), .O_RX_CLK(rx_ck), .O_RX_DATA(rx_d), .O_BUILDOUT(bo),
        .O_B8ZS_EN(b8zs), .O_RAM_PULSE_SEL(ramp), .O_RX_POWER_DOWN(rpd),
        .O_DRIVER_HIGH_Z(hiz), .O_CAL_RESTART(cal), .O_INT_N(int_n)
    );

    // --------
    // Clocks and helpers
    // --------
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial begin
        tck = 1'b0;
        forever begin
            repeat (5) @(posedge mclk);
            #1 tck = ~tck;
        end
    end

    always @(posedge mclk) begin
        if (cal === 1'b1) cal_seen <= 1'b1;
    end

    initial begin
        repeat (60000) @(posedge mclk);
        fail_count++;
        final_report();
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic gap(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : gap

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        u_host.xfer(1'b0, a, d, rv);
    endtask : wr

    task automatic rd(input logic [5:0] a);
        u_host.xfer(1'b1, a, 8'h00, rv);
    endtask : rd

    // Receive clock stands still between bursts
    task automatic rxb(input int n, input logic v);
        repeat (n) begin
            rdat = v;
            rck  = 1'b0;
            gap(5);
            rck  = 1'b1;
            gap(5);
        end
        rck = 1'b0;
        gap(10);
    endtask : rxb

    task automatic cap(input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge tx_lclk);
            bits[i] = tx_ldat;
        end
    endtask : cap

    // Period p with a single mark per period
    task automatic pat(input int p);
        int s;
        s = 0;
        gap(25);
        cap(15);
        for (int i = 0; i < 15; i++) begin
            if (i < p) s += bits[i];
            if (i + p < 15) chk({7'h00, bits[i]}, {7'h00, bits[i+p]});
        end
        chk(s[7:0], 8'h01);
    endtask : pat

    task automatic final_report();
        if (fail_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report

    // --------
    // Tests
    // --------
    initial begin
        {rst_n, tpos, tx_negative_data_in, rck, rdat, nl_det, ones, cal_seen} = 8'h00;
        fail_count  = 0;
        checks_done = 0;
        repeat (16) @(posedge mclk);
        #1 rst_n = 1'b1;
        gap(3);
        chk({int_n, cal, hiz, rpd, ramp, b8zs, bo}, 8'h80);
        rd(6'h10);
        chk(rv, 8'h00);
        rd(6'h11);
        chk(rv, 8'h00);
        rd(6'h14);
        chk(rv, 8'h00);
        for (int c = 0; c < 4; c++) begin
            wr(6'h10, {3'b000, c[1:0], 3'b000});
            chk({6'h00, bo}, {6'h00, c[1:0]});
            rd(6'h10);
            chk(rv, {3'b000, c[1:0], 3'b000});
        end
        tpos = 1'b1;
        tx_negative_data_in = 1'b1;
        wr(6'h10, 8'h04);
        chk({7'h00, b8zs}, 8'h01);
        tx_negative_data_in = 1'b0;
        gap(25);
        chk({7'h00, b8zs}, 8'h00);
        cap(2);
        chk({7'h00, bits[1]}, 8'h00);
        tpos = 1'b0;
        wr(6'h10, 8'h80);
        cap(2);
        chk({7'h00, bits[1]}, 8'h01);
        wr(6'h10, 8'h00);
        wr(6'h11, 8'h08);
        pat(5);
        wr(6'h11, 8'h10);
        pat(3);
        wr(6'h11, 8'h46);
        chk({5'h00, ramp, rpd, hiz}, 8'h07);
        wr(6'h11, 8'h00);
        // --------
        // Status, interrupts, loopbacks and double-loopback clear
        // --------
        rxb(174, 1'b0);
        rd(6'h10);
        chk({6'h00, rv[0], int_n}, 8'h01);
        rxb(1, 1'b0);
        chk({7'h00, int_n}, 8'h00);
        rd(6'h10);
        chk(rv, 8'h01);
        chk({7'h00, int_n}, 8'h00);
        wr(6'h10, 8'h01);
        chk({7'h00, int_n}, 8'h01);
        rxb(1, 1'b1);
        rd(6'h10);
        chk(rv, 8'h00);
        chk({7'h00, int_n}, 8'h01);
        wr(6'h10, 8'h00);
        rxb(175, 1'b0);
        chk({7'h00, int_n}, 8'h00);
        wr(6'h10, 8'h01);
        rxb(1, 1'b1);
        chk({7'h00, int_n}, 8'h01);
        nl_det = 1'b1;
        gap(6);
        rd(6'h10);
        chk(rv, 8'h02);
        chk({7'h00, int_n}, 8'h00);
        wr(6'h10, 8'h03);
        nl_det = 1'b0;
        gap(6);
        chk({7'h00, int_n}, 8'h01);
        ones = 1'b1;
        gap(6);
        rd(6'h11);
        chk(rv, 8'h80);
        chk({7'h00, int_n}, 8'h00);
        ones = 1'b0;
        gap(6);
        chk({7'h00, int_n}, 8'h00);
        rd(6'h11);
        rd(6'h11);
        chk(rv, 8'h00);
        chk({7'h00, int_n}, 8'h01);
        ones = 1'b1;
        wr(6'h11, 8'h80);
        gap(6);
        chk({7'h00, int_n}, 8'h01);
        ones = 1'b0;
        wr(6'h10, 8'h43);
        tpos = 1'b1;
        gap(30);
        cap(2);
        chk({6'h00, bits[1], rx_d}, 8'h03);
        @(posedge rx_ck);
        chk({7'h00, tck}, 8'h01);
        wr(6'h10, 8'hA3);
        rxb(3, 1'b1);
        chk({6'h00, tx_ldat, rx_d}, 8'h03);
        rxb(3, 1'b0);
        chk({6'h00, tx_ldat, rx_d}, 8'h00);
        wr(6'h11, 8'h46);
        wr(6'h10, 8'h60);
        chk({4'h0, cal_seen, ramp, rpd, hiz}, 8'h08);
        rd(6'h10);
        chk(rv, 8'h00);
        rd(6'h11);
        chk(rv, 8'h00);
        final_report();
    end
endmodule : t1_line_unit_control_regs_tb
